// ==== core/boot_mode_select_reset.sv ====
// Purpose: boot mode capture, chip select pin control and reset entry
// Assumes: straps hardwired; core_clk is the external input clock
// Notes:   chip select low the cycle after a bus master eprom boot fetch request while running
//
// Function
// RULE_01: eprom strap high selects 8-bit eprom boot
// RULE_02: eprom mode drives select pin as chip select
// RULE_03: straps 0 0 1 select host boot
// RULE_04: straps 0 1 1 select link boot
// RULE_05: select low means execute external memory
// RULE_06: system never applies reserved strap combinations
// RULE_07: only bus master drives select output
// RULE_08: select pin three-state only in eprom mode
// RULE_09: straps should be hardwired by system
// RULE_10: reset gives known state, reset vector
// RULE_11: system holds reset low at power-up
// RULE_12: system pulses or holds test reset low
// RULE_13: one instruction cycle per input clock
// RULE_14: input clock never halted or slowed
// RULE_15: straps sampled in reset, held afterwards
`timescale 1ns/1ps
`include "boot_mode_params.svh"

module boot_mode_select_reset
    import boot_mode_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `STRAP_SETTLE_CYC
)
(
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    input  wire logic                        test_rst_n,
    input  wire logic                        eprom_boot_strap,
    input  wire logic                        link_boot_strap,
    input  wire logic                        boot_memory_select_n_in,
    output logic                             boot_memory_select_n_out,
    output logic                             boot_memory_select_n_oe,
    input  wire logic                        bus_master,
    input  wire logic                        boot_fetch_req,
    output boot_mode_t                       boot_mode,
    output logic                             mode_reserved,
    output logic                             core_run,
    output logic                             fetch_valid,
    output logic [`RESET_VECTOR_W-1:0]       fetch_addr,
    output logic                             test_logic_ready
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic       rst_meta;
    logic       rst_sync_n;

    // async assert, two-stage release so every flop leaves reset together
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ************************************************************
    // strap capture
    // ************************************************************
    strap_t     straps_now;
    boot_mode_t decoded;
    logic       in_reset;

    assign straps_now = '{eprom_boot: eprom_boot_strap,
                          link_boot:  link_boot_strap,
                          select_in:  boot_memory_select_n_in};

    boot_strap_decode u_decode
    (
        .straps (straps_now),
        .mode   (decoded)
    );

    assign in_reset = !rst_sync_n;

    // sampled by the clock while reset is held, frozen after; never loaded
    // from a port in the async branch
    always_ff @(posedge core_clk)
    begin
        if (in_reset)
        begin
            boot_mode     <= decoded;                       // [RULE_15]
            mode_reserved <= (decoded == BOOT_RESERVED);    // [RULE_06]
        end
    end

    // ************************************************************
    // reset entry sequence
    // ************************************************************
    seq_state_t                 state;
    logic [`SETTLE_CNT_W-1:0]   settle;

    // settle window delays execution after reset release; the straps are already frozen by then
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            state  <= SEQ_RESET;                            // [RULE_10]
            settle <= '0;
        end
        else
        begin
            unique case (state)
                SEQ_RESET:
                begin
                    state  <= SEQ_SETTLE;
                    settle <= '0;
                end
                SEQ_SETTLE:
                begin
                    if (settle >= `SETTLE_CNT_W'(SETTLE_CYC - 1))
                        state <= SEQ_RUN;
                    else
                        settle <= settle + `SETTLE_CNT_W'(1);
                end
                SEQ_RUN:
                    state <= SEQ_RUN;
            endcase
        end
    end

    // ************************************************************
    // execution start and fetch
    // ************************************************************
    // reserved straps never start execution
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            core_run    <= 1'b0;
            fetch_valid <= 1'b0;
            fetch_addr  <= `RESET_VECTOR_VAL;               // [RULE_10]
        end
        else if (state == SEQ_RUN && !mode_reserved)
        begin
            core_run    <= 1'b1;
            fetch_valid <= 1'b1;                            // [RULE_13]
            if (core_run)
                fetch_addr <= fetch_addr + `RESET_VECTOR_W'(1); // [RULE_13]
        end
    end

    // ************************************************************
    // boot memory select pin
    // ************************************************************
    // pin is input unless eprom mode; then only bus master drives it
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            boot_memory_select_n_out <= 1'b1;
            boot_memory_select_n_oe  <= 1'b0;
        end
        else
        begin
            boot_memory_select_n_oe  <= (boot_mode == BOOT_EPROM) && bus_master; // [RULE_07] [RULE_08]
            boot_memory_select_n_out <= !((boot_mode == BOOT_EPROM) && bus_master
                                          && boot_fetch_req && core_run);        // [RULE_02]
        end
    end

    // ************************************************************
    // test logic reset
    // ************************************************************
    // ready once the system has pulsed or held test reset low
    always_ff @(posedge core_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            test_logic_ready <= 1'b0;
        else if (!test_rst_n)
            test_logic_ready <= 1'b1;                       // [RULE_12]
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence run_reached_s;
        state == SEQ_RUN;
    endsequence

    property oe_only_eprom_p;
        @(posedge core_clk) disable iff (!rst_sync_n)
        boot_memory_select_n_oe |-> (boot_mode == BOOT_EPROM);
    endproperty
    select_oe_mode_a: assert property (oe_only_eprom_p)     // [RULE_08]
        else $error("select pin driven outside eprom mode");

    select_oe_master_a: assert property                     // [RULE_07]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         boot_memory_select_n_oe |-> $past(bus_master))
        else $error("select pin driven without bus mastership");

    mode_frozen_a: assert property                          // [RULE_15]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         $stable(boot_mode))
        else $error("boot mode changed after reset");

    // judged against the raw straps so a decoder slip cannot hide here
    reserved_flag_a: assert property                        // [RULE_06]
        (@(posedge core_clk)
         in_reset |=> mode_reserved == (($past(eprom_boot_strap) && $past(link_boot_strap))
                                        || (!$past(eprom_boot_strap) && $past(link_boot_strap)
                                            && !$past(boot_memory_select_n_in))))
        else $error("reserved flag disagrees with straps");

    run_start_a: assert property                            // [RULE_10]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         $rose(core_run) |-> fetch_addr == `RESET_VECTOR_VAL)
        else $error("execution not started at reset vector");

    run_bound_a: assert property                            // [RULE_10]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         $rose(rst_sync_n) |-> ##[1:20] run_reached_s)
        else $error("reset sequence did not reach run");

    fetch_rate_a: assert property                           // [RULE_13]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         core_run && $past(core_run) |-> fetch_addr == $past(fetch_addr) + 32'h1)
        else $error("fetch not one per clock");

    chip_sel_a: assert property                             // [RULE_02]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         !boot_memory_select_n_out |-> boot_memory_select_n_oe && core_run)
        else $error("chip select low while not driving");

    cs_follow_req_a: assert property                        // [RULE_02]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         boot_fetch_req && bus_master && core_run && boot_mode == BOOT_EPROM
         |=> !boot_memory_select_n_out)
        else $error("chip select not asserted for eprom fetch");

    no_run_reserved_a: assert property                      // [RULE_06]
        (@(posedge core_clk) disable iff (!rst_sync_n)
         mode_reserved |-> !core_run)
        else $error("execution started with reserved straps");

endmodule : boot_mode_select_reset

// ==== core/boot_strap_decode.sv ====
// Purpose: combinational decode of the three boot straps
// Assumes: straps are static while sampled
// Notes:   reserved combinations map to their own code
`timescale 1ns/1ps
`include "boot_mode_params.svh"

module boot_strap_decode
    import boot_mode_pkg::*;
(
    input  wire strap_t     straps,
    output boot_mode_t      mode
);

    // ************************************************************
    // decode
    // ************************************************************
    // eprom high with link low wins, then link and select pick the rest
    always_comb
    begin
        mode = BOOT_RESERVED;
        if (straps.eprom_boot)
        begin
            if (!straps.link_boot)
                mode = BOOT_EPROM;                          // [RULE_01] [RULE_02]
        end
        else if (!straps.select_in)
        begin
            if (!straps.link_boot)
                mode = BOOT_NONE;                           // [RULE_05]
        end
        else if (straps.link_boot)
            mode = BOOT_LINK;                               // [RULE_04]
        else
            mode = BOOT_HOST;                               // [RULE_03]
    end

endmodule : boot_strap_decode

// ==== inc/boot_mode_params.svh ====
// Purpose: timing counts and reset values for boot mode select and reset entry
// Assumes: single core clock at 200 MHz
// Notes:   definitions only
`ifndef BOOT_MODE_PARAMS_SVH
`define BOOT_MODE_PARAMS_SVH

// ************************************************************
// clock and timing
// ************************************************************
`define CLK_PERIOD_PS      5000
`define RESET_VECTOR_W     32
`define RESET_VECTOR_VAL   32'h0000_0000
`define STRAP_SETTLE_NS    20
`define STRAP_SETTLE_CYC   ((`STRAP_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETTLE_CNT_W       4

`endif

// ==== inc/boot_mode_pkg.sv ====
// Purpose: types for boot mode select and reset entry
// Assumes: included constants header for numbers
// Notes:   enumerations and the strap bundle struct only
package boot_mode_pkg;

    // ************************************************************
    // boot source decode
    // ************************************************************
    typedef enum logic [2:0]
    {
        BOOT_EPROM,
        BOOT_HOST,
        BOOT_LINK,
        BOOT_NONE,
        BOOT_RESERVED
    } boot_mode_t;

    // strap sample carried as one bundle
    typedef struct packed
    {
        logic eprom_boot;
        logic link_boot;
        logic select_in;
    } strap_t;

    // reset entry sequence
    typedef enum logic [1:0]
    {
        SEQ_RESET,
        SEQ_SETTLE,
        SEQ_RUN
    } seq_state_t;

endpackage : boot_mode_pkg

// ==== tb/boot_board_model.sv ====
// Purpose: board straps and boot eprom chip select model
// Assumes: straps static for each run, set by the bench
// Notes:   undriven select pin falls back to its strap level
`timescale 1ns/1ps

module boot_board_model
(
    input  wire logic       core_clk,
    input  wire logic [2:0] cfg,
    input  wire logic       sel_out,
    input  wire logic       sel_oe,
    output logic            eprom_boot_strap,
    output logic            link_boot_strap,
    output logic            sel_pin,
    output logic [7:0]      cs_cycles
);
    // hardwired straps, reserved ones only when the bench asks
    assign eprom_boot_strap = cfg[2];
    assign link_boot_strap  = cfg[1];
    // resolved pin: the device wins while it drives, else the strap pull
    assign sel_pin = sel_oe ? sel_out : cfg[0];
    // eprom counts the cycles in which it is selected
    logic [7:0] cs_count = 8'h00;
    always @(posedge core_clk)
        if (sel_oe && !sel_out)
            cs_count <= cs_count + 8'h01;
    assign cs_cycles = cs_count;
endmodule : boot_board_model

// ==== tb/boot_mode_select_reset_test.sv ====
// Purpose: self-checking bench for boot mode select and reset entry
// Assumes: inputs driven at falling edge, short settle count
// Notes:   every scenario passes through a fresh reset
`timescale 1ns/1ps
`include "boot_mode_params.svh"

module boot_mode_select_reset_test;
    import boot_mode_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic test_rst_n = 1'b1;
    logic bus_master = 1'b0;
    logic boot_fetch_req = 1'b0;
    logic [2:0] cfg = 3'h4;
    logic eb, lb, sel_pin, sel_out, sel_oe, mode_reserved, core_run, fetch_valid, tlr;
    logic [7:0] cs_cycles;
    logic [31:0] fetch_addr;
    boot_mode_t boot_mode;
    int error_cnt = 0;
    int checked = 0;

    // ************************************************************
    // clock and units
    // ************************************************************
    always #2.5 core_clk = ~core_clk; // never halted

    boot_board_model board (.core_clk(core_clk), .cfg(cfg), .sel_out(sel_out),
        .sel_oe(sel_oe), .eprom_boot_strap(eb), .link_boot_strap(lb),
        .sel_pin(sel_pin), .cs_cycles(cs_cycles));

    boot_mode_select_reset #(.SETTLE_CYC(2)) uut (.core_clk(core_clk), .rst_n(rst_n),
        .test_rst_n(test_rst_n), .eprom_boot_strap(eb), .link_boot_strap(lb),
        .boot_memory_select_n_in(sel_pin), .boot_memory_select_n_out(sel_out),
        .boot_memory_select_n_oe(sel_oe), .bus_master(bus_master),
        .boot_fetch_req(boot_fetch_req), .boot_mode(boot_mode),
        .mode_reserved(mode_reserved), .core_run(core_run), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .test_logic_ready(tlr));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    // reset with given straps, held 4 cycles, optionally wait for run
    task automatic boot(input logic [2:0] v, input bit wait_run);
        int i;
        rst_n = 1'b0; // asserted at power-up too
        cfg = v;
        cyc(4);
        check("vector", fetch_addr, `RESET_VECTOR_VAL);
        check("run_in_reset", core_run, 1'b0);
        rst_n = 1'b1;
        for (i = 0; i < 40 && wait_run && core_run !== 1'b1; i++)
            cyc(1);
        if (i == 40)
        begin
            error_cnt++;
            $display("BAD core_run expected 1 seen %b", core_run);
            finish_test();
        end
    endtask : boot

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_modes();
        logic [2:0] v [5] = '{3'h4, 3'h5, 3'h1, 3'h3, 3'h0};
        boot_mode_t m [5] = '{BOOT_EPROM, BOOT_EPROM, BOOT_HOST, BOOT_LINK, BOOT_NONE};
        for (int k = 0; k < 5; k++)
        begin
            boot(v[k], 1);
            check("mode", boot_mode, m[k]);
            check("reserved", mode_reserved, 1'b0);
            check("oe_slave", sel_oe, 1'b0);
            check("valid", fetch_valid, 1'b1);
            bus_master = 1'b1;
            cyc(2);
            check("oe_master", sel_oe, m[k] == BOOT_EPROM);
            bus_master = 1'b0;
        end
        $display("modes done");
    endtask : t_modes

    task automatic t_reserved();
        logic [2:0] v [3] = '{3'h2, 3'h6, 3'h7};
        for (int k = 0; k < 3; k++)
        begin
            boot(v[k], 0);
            bus_master = 1'b1;
            cyc(30);
            check("res_flag", mode_reserved, 1'b1);
            check("res_run", core_run, 1'b0);
            check("res_oe", sel_oe, 1'b0);
            bus_master = 1'b0;
        end
        $display("reserved done");
    endtask : t_reserved

    task automatic t_eprom();
        logic [7:0] n0;
        boot(3'h4, 1);
        bus_master = 1'b1;
        cyc(1);
        check("oe_on", sel_oe, 1'b1);
        n0 = cs_cycles;
        boot_fetch_req = 1'b1;
        cyc(1);
        check("cs_low", sel_out, 1'b0);
        cyc(2);
        boot_fetch_req = 1'b0;
        cyc(2);
        check("cs_idle", sel_out, 1'b1);
        check("cs_count", cs_cycles - n0, 8'h03);
        bus_master = 1'b0;
        cyc(1);
        check("oe_off", sel_oe, 1'b0);
        // a fetch request without mastership must leave the pin alone
        boot_fetch_req = 1'b1;
        n0 = cs_cycles;
        cyc(3);
        check("cs_slave", sel_out, 1'b1);
        check("cs_slave_count", cs_cycles - n0, 8'h00);
        boot_fetch_req = 1'b0;
        $display("eprom done");
    endtask : t_eprom

    task automatic t_hold();
        logic [31:0] a;
        boot(3'h1, 1);
        a = fetch_addr;
        cfg = 3'h4;
        cyc(4);
        check("mode_held", boot_mode, BOOT_HOST);
        check("addr_step", fetch_addr, a + 32'h4);
        rst_n = 1'b0;
        cyc(1);
        check("run_drop", core_run, 1'b0);
        cyc(3);
        check("mode_resample", boot_mode, BOOT_EPROM);
        rst_n = 1'b1;
        $display("hold done");
    endtask : t_hold

    task automatic t_test_reset();
        boot(3'h0, 1);
        check("tlr_clear", tlr, 1'b0);
        test_rst_n = 1'b0; // pulsed low after power-up
        cyc(2);
        test_rst_n = 1'b1;
        cyc(2);
        check("tlr_set", tlr, 1'b1);
        $display("test reset done");
    endtask : t_test_reset

    // main sequence
    initial
    begin
        t_test_reset();
        t_modes();
        t_reserved();
        t_eprom();
        t_hold();
        finish_test();
    end
endmodule : boot_mode_select_reset_test
